// *** src/slr_pkg.sv ***
// Constants and types for the security, lock and reset command block.
package slr_pkg;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_SEC_PROG   = 8'h42;
   localparam logic [7:0] OP_SEC_READ   = 8'h48;
   localparam logic [7:0] OP_BLK_LOCK   = 8'h36;
   localparam logic [7:0] OP_BLK_UNLOCK = 8'h39;
   localparam logic [7:0] OP_BLK_READ   = 8'h3d;
   localparam logic [7:0] OP_GLB_LOCK   = 8'h7e;
   localparam logic [7:0] OP_GLB_UNLOCK = 8'h98;
   localparam logic [7:0] OP_RST_EN     = 8'h66;
   localparam logic [7:0] OP_RST        = 8'h99;

   // ----------------------------------------------------------------
   // Address layout
   // ----------------------------------------------------------------
   localparam int         SEC_REGS      = 3;
   localparam int         SEC_BYTES     = 256;
   localparam logic [7:0] ERASED_BYTE   = 8'hff;
   localparam int         SEL_LSB       = 12;
   localparam int         PAD_LSB       = 8;
   localparam int         UPPER_LSB     = 16;
   localparam logic [3:0] SEL_FIRST     = 4'h1;
   localparam logic [3:0] SEL_LAST      = 4'h3;
   localparam logic [3:0] PAD_VALUE     = 4'h0;
   localparam int         BLK_LSB       = 16;
   localparam int         BLK_W         = 9;
   localparam int         NUM_BLOCKS    = 512;
   localparam logic [2:0] ADDR_BYTES_3  = 3'h3;
   localparam logic [2:0] ADDR_BYTES_4  = 3'h4;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int RST_TIME_NS   = 30000;
   localparam int PROG_TIME_NS  = 1000;
   localparam int TMR_W         = 16;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_DATA_OUT, ST_IGNORE
   } slr_state_t;

   typedef struct packed {
      logic       addr_4byte;
      logic       write_latch;
      logic       protect_scheme_select;
      logic       range_protect_hit;
      logic       die_active;
      logic [2:0] otp_lock_bits;
   } slr_cfg_t;

   typedef struct packed {
      logic busy;
      logic reset_recovery;
      logic soft_reset;
      logic write_latch_clear;
      logic prog_blocked;
   } slr_stat_t;

endpackage

// *** src/slr_core.sv ***
// Security register, block lock and software reset instruction handling.
`timescale 1ns/100ps
module slr_core
   import slr_pkg::*;
#(
   parameter int unsigned RST_CYCLES  = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
   parameter int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
   // System clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // Serial link
   input  wire logic             spi_clk,
   input  wire logic             spi_cs_n,
   input  wire logic             serial_in,
   output logic                  serial_out,
   output logic                  serial_oe,
   // Configuration and status
   input  wire slr_cfg_t         cfg,
   input  wire logic [BLK_W-1:0] prog_check_block,
   output slr_stat_t             stat
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic             link_rst_reg;
   logic [2:0]       bit_cnt_reg;
   logic [6:0]       rx_shift_reg;
   logic [7:0]       rx_byte_reg;
   logic             rx_tgl_reg;
   logic [7:0]       tx_shift_reg;
   logic             oe_s1_reg;
   logic             oe_s2_reg;
   logic             tgl_s1_reg;
   logic             tgl_s2_reg;
   logic             tgl_s3_reg;
   logic             cs_s1_reg;
   logic             cs_s2_reg;
   logic             cs_s3_reg;
   logic             cs_s4_reg;
   slr_state_t       state_reg;
   logic [7:0]       opcode_reg;
   logic [2:0]       byte_cnt_reg;
   logic [31:0]      addr_reg;
   logic [7:0]       off_reg;
   logic [1:0]       sel_idx_reg;
   logic             sel_ok_reg;
   logic             prog_ok_reg;
   logic             ignore_reg;
   logic             armed_reg;
   logic [7:0]       tx_word_reg;
   logic             tx_en_reg;
   logic [7:0]       sec_mem [0:SEC_REGS*SEC_BYTES-1];
   logic [NUM_BLOCKS-1:0] lock_reg;
   logic [TMR_W-1:0] tmr_reg;
   logic             busy_reg;
   logic             recov_reg;
   logic             soft_rst_reg;
   logic             wel_clr_reg;
   logic             blocked_reg;
   logic             byte_evt;
   logic             frame_end;
   logic             frame_ok;
   logic [2:0]       alen;
   logic [31:0]      addr_next;
   logic [3:0]       sel_next;
   logic             sel_ok_next;
   logic [1:0]       sel_idx_next;
   logic [7:0]       off_inc;
   logic             reset_op;
   logic             rst_accept;
   logic             prog_start;
   logic             one_byte;

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   // Held high by system reset so the toggle starts from a known level.
   always_ff @(posedge clk_sys) begin
      link_rst_reg <= ~rstn;
   end

   // Byte value and toggle survive chip select rising, because the last byte
   // may still be in flight towards the system side when the frame ends.
   always_ff @(posedge spi_clk or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         rx_byte_reg <= 8'h00;
         rx_tgl_reg  <= 1'b0;
      end else if (bit_cnt_reg == 3'h7) begin
         rx_byte_reg <= {rx_shift_reg, serial_in};
         rx_tgl_reg  <= ~rx_tgl_reg;
      end
   end

   always_ff @(posedge spi_clk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         bit_cnt_reg  <= 3'h0;
         rx_shift_reg <= 7'h00;
         tx_shift_reg <= 8'h00;
         oe_s1_reg    <= 1'b0;
         oe_s2_reg    <= 1'b0;
      end else begin
         bit_cnt_reg  <= bit_cnt_reg + 3'h1;
         rx_shift_reg <= {rx_shift_reg[5:0], serial_in};
         oe_s1_reg    <= tx_en_reg;
         oe_s2_reg    <= oe_s1_reg;
         // The word is held stable by the system side for a whole byte.
         if (bit_cnt_reg == 3'h7) begin
            tx_shift_reg <= tx_word_reg;
         end else begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(negedge spi_clk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         serial_out <= 1'b0;
         serial_oe  <= 1'b0;
      end else begin
         serial_out <= tx_shift_reg[7];
         serial_oe  <= oe_s2_reg;
      end
   end
   // ----------------------------------------------------------------
   // Crossing into the system domain
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
         cs_s1_reg  <= 1'b1;
         cs_s2_reg  <= 1'b1;
         cs_s3_reg  <= 1'b1;
         cs_s4_reg  <= 1'b1;
      end else begin
         tgl_s1_reg <= rx_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         cs_s1_reg  <= spi_cs_n;
         cs_s2_reg  <= cs_s1_reg;
         cs_s3_reg  <= cs_s2_reg;
         cs_s4_reg  <= cs_s3_reg;
      end
   end

   // Frame end is one stage later so a last byte is always decoded first.
   assign byte_evt  = tgl_s2_reg ^ tgl_s3_reg;
   assign frame_end = cs_s3_reg & ~cs_s4_reg;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   assign alen         = cfg.addr_4byte ? ADDR_BYTES_4 : ADDR_BYTES_3;
   assign addr_next    = {addr_reg[23:0], rx_byte_reg};
   assign sel_next     = addr_next[SEL_LSB +: 4];
   assign sel_ok_next  = (sel_next >= SEL_FIRST) && (sel_next <= SEL_LAST)
                         && (addr_next[PAD_LSB +: 4] == PAD_VALUE)
                         && (addr_next[31:UPPER_LSB] == 16'h0000);
   assign sel_idx_next = 2'(sel_next - SEL_FIRST);
   assign off_inc      = off_reg + 8'h01;
   assign reset_op     = (rx_byte_reg == OP_RST_EN) || (rx_byte_reg == OP_RST);
   assign one_byte     = byte_cnt_reg == 3'h1;
   assign frame_ok     = frame_end && !ignore_reg;
   assign rst_accept   = frame_ok && (opcode_reg == OP_RST) && one_byte && armed_reg;
   assign prog_start   = frame_ok && (opcode_reg == OP_SEC_PROG) && prog_ok_reg
                         && (byte_cnt_reg >= alen + 3'h2);

   function automatic logic [7:0] sec_read(input logic ok, input logic [1:0] idx,
                                           input logic [7:0] off);
      sec_read = ok ? sec_mem[{idx, off}] : ERASED_BYTE;
   endfunction

   // ----------------------------------------------------------------
   // Instruction sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn || rst_accept) begin
         state_reg    <= ST_OPCODE;
         opcode_reg   <= 8'h00;
         byte_cnt_reg <= 3'h0;
         addr_reg     <= 32'h0;
         off_reg      <= 8'h00;
         sel_idx_reg  <= 2'h0;
         sel_ok_reg   <= 1'b0;
         prog_ok_reg  <= 1'b0;
         ignore_reg   <= 1'b0;
         armed_reg    <= 1'b0;
         tx_word_reg  <= 8'h00;
         tx_en_reg    <= 1'b0;
      end else if (frame_end) begin
         state_reg    <= ST_OPCODE;
         byte_cnt_reg <= 3'h0;
         addr_reg     <= 32'h0;
         prog_ok_reg  <= 1'b0;
         tx_en_reg    <= 1'b0;
         // An empty frame is no instruction and leaves the armed state alone.
         if (byte_cnt_reg != 3'h0) begin
            armed_reg <= frame_ok && (opcode_reg == OP_RST_EN) && one_byte;
         end
      end else if (byte_evt) begin
         if (byte_cnt_reg != 3'h7) begin
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
         end
         unique case (state_reg)
            ST_OPCODE: begin
               opcode_reg <= rx_byte_reg;
               // Reset codes bypass the busy and die gates.
               ignore_reg <= recov_reg || ((busy_reg || !cfg.die_active) && !reset_op);
               if ((rx_byte_reg == OP_SEC_PROG) || (rx_byte_reg == OP_SEC_READ)
                   || (rx_byte_reg == OP_BLK_LOCK) || (rx_byte_reg == OP_BLK_UNLOCK)
                   || (rx_byte_reg == OP_BLK_READ)) begin
                  state_reg <= ST_ADDR;
               end else begin
                  state_reg <= ST_IGNORE;
               end
            end
            ST_ADDR: begin
               addr_reg <= addr_next;
               if (byte_cnt_reg == alen) begin
                  off_reg     <= addr_next[7:0];
                  sel_idx_reg <= sel_idx_next;
                  sel_ok_reg  <= sel_ok_next;
                  prog_ok_reg <= sel_ok_next && cfg.write_latch
                                 && !cfg.otp_lock_bits[sel_idx_next];
                  if (opcode_reg == OP_SEC_READ) begin
                     state_reg   <= ST_DUMMY;
                     tx_word_reg <= sec_read(sel_ok_next, sel_idx_next, addr_next[7:0]);
                     tx_en_reg   <= !ignore_reg;
                  end else if (opcode_reg == OP_SEC_PROG) begin
                     state_reg <= ST_DATA_IN;
                  end else if (opcode_reg == OP_BLK_READ) begin
                     state_reg <= ST_DATA_OUT;
                  end else begin
                     state_reg <= ST_IGNORE;
                  end
               end else if ((opcode_reg == OP_BLK_READ) && (byte_cnt_reg == alen - 3'h1)) begin
                  // The block index is known one byte early, giving the link a byte of slack.
                  tx_word_reg <= {7'h00, lock_reg[addr_next[BLK_LSB-8 +: BLK_W]]};
                  tx_en_reg   <= !ignore_reg;
               end
            end
            ST_DUMMY, ST_DATA_OUT: begin
               state_reg <= ST_DATA_OUT;
               if (opcode_reg == OP_SEC_READ) begin
                  off_reg     <= off_inc;
                  tx_word_reg <= sec_read(sel_ok_reg, sel_idx_reg, off_inc);
               end
            end
            ST_DATA_IN: off_reg <= off_inc;
            ST_IGNORE: state_reg <= ST_IGNORE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Security register storage
   // ----------------------------------------------------------------
   // Bytes are written as they arrive; programming only clears bits.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         for (int i = 0; i < SEC_REGS * SEC_BYTES; i++) begin
            sec_mem[i] <= ERASED_BYTE;
         end
      end else if (byte_evt && (state_reg == ST_DATA_IN) && prog_ok_reg && !ignore_reg
                   && !frame_end) begin
         sec_mem[{sel_idx_reg, off_reg}] <= sec_mem[{sel_idx_reg, off_reg}] & rx_byte_reg;
      end
   end

   // ----------------------------------------------------------------
   // Block lock bits
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn || rst_accept) begin
         lock_reg <= '1;
      end else if (frame_ok && one_byte && (opcode_reg == OP_GLB_LOCK)) begin
         lock_reg <= '1;
      end else if (frame_ok && one_byte && (opcode_reg == OP_GLB_UNLOCK)) begin
         lock_reg <= '0;
      end else if (frame_ok && (byte_cnt_reg == alen + 3'h1)) begin
         if (opcode_reg == OP_BLK_LOCK) begin
            lock_reg[addr_reg[BLK_LSB +: BLK_W]] <= 1'b1;
         end else if (opcode_reg == OP_BLK_UNLOCK) begin
            lock_reg[addr_reg[BLK_LSB +: BLK_W]] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         blocked_reg <= 1'b0;
      end else if (cfg.protect_scheme_select) begin
         blocked_reg <= lock_reg[prog_check_block];
      end else begin
         blocked_reg <= cfg.range_protect_hit;
      end
   end

   // ----------------------------------------------------------------
   // Busy, recovery and reset outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tmr_reg      <= '0;
         busy_reg     <= 1'b0;
         recov_reg    <= 1'b0;
         soft_rst_reg <= 1'b0;
         wel_clr_reg  <= 1'b0;
      end else begin
         soft_rst_reg <= rst_accept;
         wel_clr_reg  <= prog_start;
         if (rst_accept) begin
            // Aborts a running program; the host should have checked busy first.
            busy_reg  <= 1'b0;
            recov_reg <= 1'b1;
            tmr_reg   <= TMR_W'(RST_CYCLES);
         end else if (prog_start) begin
            busy_reg <= 1'b1;
            tmr_reg  <= TMR_W'(PROG_CYCLES);
         end else if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - TMR_W'(1);
            if (tmr_reg == TMR_W'(1)) begin
               busy_reg  <= 1'b0;
               recov_reg <= 1'b0;
            end
         end
      end
   end

   assign stat.busy              = busy_reg;
   assign stat.reset_recovery    = recov_reg;
   assign stat.soft_reset        = soft_rst_reg;
   assign stat.write_latch_clear = wel_clr_reg;
   assign stat.prog_blocked      = blocked_reg;

endmodule

// *** tb/slr_host_model.sv ***
// Host serial controller model that frames instructions for the block.
`timescale 1ns/100ps
module slr_host_model (
   // Serial link
   output logic      spi_clk,
   output logic      spi_cs_n,
   output logic      serial_in,
   input  wire logic serial_out
);
   initial begin
      spi_clk   = 1'b0;
      spi_cs_n  = 1'b0;
      serial_in = 1'b1;
      // A clean rising chip select at start-up clears the link-side output flops.
      #1 spi_cs_n = 1'b1;
   end

   // The link clock only runs inside a frame; the small offset keeps it off the system grid.
   task automatic frame(input logic [7:0] tx [$], input int nrx, output logic [7:0] rx [$]);
      logic [7:0] b;
      rx = {};
      #0.7 spi_cs_n = 1'b0;
      #10;
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            serial_in = tx[i][k];
            #15 spi_clk = 1'b1;
            #15 spi_clk = 1'b0;
         end
      end
      for (int n = 0; n < nrx; n++) begin
         for (int k = 7; k >= 0; k--) begin
            serial_in = ~serial_in;
            #15 spi_clk = 1'b1;
            b[k] = serial_out;
            #15 spi_clk = 1'b0;
         end
         rx.push_back(b);
      end
      #10 spi_cs_n = 1'b1;
      serial_in = ~serial_in;
      #60;
   endtask
endmodule

// *** tb/slr_core_asserts.sv ***
// Concurrent checks on the ports of the instruction block.
`timescale 1ns/100ps
module slr_core_asserts
   import slr_pkg::*;
#(
   parameter int unsigned RST_CYCLES  = 50,
   parameter int unsigned PROG_CYCLES = 20
) (
   // Clocks and reset
   input wire logic             clk_sys,
   input wire logic             rstn,
   input wire logic             spi_clk,
   // Serial link
   input wire logic             spi_cs_n,
   input wire logic             serial_in,
   input wire logic             serial_out,
   input wire logic             serial_oe,
   // Configuration and status
   input wire slr_cfg_t         cfg,
   input wire logic [BLK_W-1:0] prog_check_block,
   input wire slr_stat_t        stat
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   logic [15:0] busy_cnt;
   logic [15:0] rec_cnt;

   always_ff @(posedge clk_sys) begin
      if (!rstn || !stat.busy) busy_cnt <= 16'h0;
      else busy_cnt <= busy_cnt + 16'h1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || !stat.reset_recovery) rec_cnt <= 16'h0;
      else rec_cnt <= rec_cnt + 16'h1;
   end

   sequence rec_run;
      stat.reset_recovery [*8];
   endsequence
   sequence busy_run;
      stat.busy [*8];
   endsequence

   reset_enters_recovery_a: assert property (stat.soft_reset |-> ##[0:2] rec_run)
      else $error("recovery did not follow reset");
   reset_pulse_once_a: assert property (stat.soft_reset |=> (!stat.soft_reset) [*8])
      else $error("reset pulse repeated");
   recovery_length_a: assert property ($fell(stat.reset_recovery) |-> rec_cnt == RST_CYCLES)
      else $error("recovery length wrong");
   recovery_no_prog_a: assert property (stat.reset_recovery |-> !stat.write_latch_clear)
      else $error("program started in recovery");
   prog_start_busy_a: assert property (stat.write_latch_clear |-> ##[0:1] busy_run)
      else $error("busy missing after program start");
   busy_length_a: assert property ($fell(stat.busy) && !stat.reset_recovery
      && !$past(stat.soft_reset) |-> busy_cnt == PROG_CYCLES) else $error("busy length wrong");
   reset_aborts_busy_a: assert property (stat.soft_reset |-> ##[1:2] !stat.busy)
      else $error("busy survived reset");
   idle_out_quiet_a: assert property (spi_cs_n && $past(spi_cs_n) |-> !serial_oe && !serial_out)
      else $error("output active while deselected");
   range_scheme_a: assert property ($past(rstn) && !$past(cfg.protect_scheme_select)
      |-> stat.prog_blocked == $past(cfg.range_protect_hit)) else $error("range protection wrong");
endmodule

bind slr_core slr_core_asserts #(.RST_CYCLES(RST_CYCLES), .PROG_CYCLES(PROG_CYCLES))
   slr_core_asserts_inst (.clk_sys(clk_sys), .rstn(rstn), .spi_clk(spi_clk),
   .spi_cs_n(spi_cs_n), .serial_in(serial_in), .serial_out(serial_out),
   .serial_oe(serial_oe), .cfg(cfg), .prog_check_block(prog_check_block), .stat(stat));

// *** tb/security_lock_reset_commands_tb.sv ***
// Self-checking bench for the security, lock and reset instruction block.
`timescale 1ns/100ps
module security_lock_reset_commands_tb
   import slr_pkg::*;
;
   logic             clk_sys;
   logic             rstn;
   logic             spi_clk;
   logic             spi_cs_n;
   logic             serial_in;
   logic             serial_out;
   logic             serial_oe;
   slr_cfg_t         cfg;
   logic [BLK_W-1:0] prog_check_block;
   slr_stat_t        stat;
   logic [7:0]       rx [$];
   int               error_cnt = 0;
   int               n_tests = 0;
   int               cyc = 0;
   int               sr_cnt = 0;
   int               wlc_cnt = 0;
   int               an = 3;

   // Short counts keep the run brief; recovery must outlast one frame plus its gap.
   slr_core #(.RST_CYCLES(200), .PROG_CYCLES(20)) slr_core_inst (.clk_sys(clk_sys),
      .rstn(rstn), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .serial_in(serial_in),
      .serial_out(serial_out), .serial_oe(serial_oe), .cfg(cfg),
      .prog_check_block(prog_check_block), .stat(stat));
   slr_host_model slr_host_model_inst (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
      .serial_in(serial_in), .serial_out(serial_out));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(negedge clk_sys) begin
      cyc++;
      if (stat.soft_reset === 1'b1) sr_cnt++;
      if (stat.write_latch_clear === 1'b1) wlc_cnt++;
      if (cyc == 30000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
         error_cnt++;
      end
   endtask

   task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na,
                      input logic [15:0] d, input int nd, input int nrx);
      logic [7:0] tx [$];
      tx = {op};
      for (int i = na - 1; i >= 0; i--) tx.push_back(a[8*i +: 8]);
      for (int i = nd - 1; i >= 0; i--) tx.push_back(d[8*i +: 8]);
      slr_host_model_inst.frame(tx, nrx, rx);
   endtask

   task automatic lockchk(input logic [31:0] a, input logic [7:0] exp);
      cmd(OP_BLK_READ, a, an, 16'h0, 0, 2);
      chk(rx[0], exp, "lock byte");
      chk(rx[1], exp, "lock byte repeat");
   endtask

   task automatic blk_check(input logic [BLK_W-1:0] b, input logic exp);
      @(negedge clk_sys);
      prog_check_block = b;
      repeat (2) @(negedge clk_sys);
      chk({7'h0, stat.prog_blocked}, {7'h0, exp}, "prog blocked");
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      while (stat.busy !== 1'b0 || stat.reset_recovery !== 1'b0) begin
         @(negedge clk_sys);
         k++;
         if (k > 400) begin
            chk(8'h1, 8'h0, "idle wait expired");
            break;
         end
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_locks();
      @(negedge clk_sys);
      cfg.protect_scheme_select = 1'b1;
      blk_check(9'h005, 1'b1);
      lockchk(32'h50000, 8'h01);
      cmd(OP_GLB_UNLOCK, 0, 0, 16'h0, 0, 0);
      lockchk(32'h50000, 8'h00);
      blk_check(9'h005, 1'b0);
      cmd(OP_BLK_LOCK, 32'h50000, an, 16'h0, 0, 0);
      lockchk(32'h50000, 8'h01);
      lockchk(32'h60000, 8'h00);
      blk_check(9'h005, 1'b1);
      cmd(OP_BLK_UNLOCK, 32'h50000, an, 16'h0, 0, 0);
      lockchk(32'h50000, 8'h00);
      cmd(OP_GLB_LOCK, 0, 0, 16'h0, 0, 0);
      lockchk(32'hff0000, 8'h01);
      @(negedge clk_sys);
      cfg.protect_scheme_select = 1'b0;
      blk_check(9'h0ff, 1'b0);
      cfg.range_protect_hit = 1'b1;
      blk_check(9'h0ff, 1'b1);
   endtask

   task automatic t_sec();
      cmd(OP_SEC_PROG, 32'h20fe, an, 16'h00a5, 1, 0);
      chk(wlc_cnt[7:0], 8'h0, "program without write latch");
      @(negedge clk_sys);
      cfg.write_latch = 1'b1;
      cmd(OP_SEC_PROG, 32'h20fe, an, 16'ha53c, 2, 0);
      chk({7'h0, stat.busy}, 8'h1, "busy during program");
      chk(wlc_cnt[7:0], 8'h1, "write latch clear pulse");
      wait_idle();
      cmd(OP_SEC_READ, 32'h20fe, an, 16'h0, 1, 4);
      chk(rx[0], 8'ha5, "sec byte fe");
      chk(rx[1], 8'h3c, "sec byte ff");
      chk(rx[2], 8'hff, "sec byte wrap 00");
      @(negedge clk_sys);
      cfg.otp_lock_bits = 3'b010;
      cmd(OP_SEC_PROG, 32'h2000, an, 16'h0000, 1, 0);
      wait_idle();
      cmd(OP_SEC_PROG, 32'h3000, an, 16'h0012, 1, 0);
      wait_idle();
      cmd(OP_SEC_READ, 32'h2000, an, 16'h0, 1, 1);
      chk(rx[0], 8'hff, "locked register kept");
      cmd(OP_SEC_READ, 32'h3000, an, 16'h0, 1, 1);
      chk(rx[0], 8'h12, "third register written");
   endtask

   task automatic t_addr4();
      @(negedge clk_sys);
      cfg.addr_4byte = 1'b1;
      an = 4;
      cmd(OP_SEC_READ, 32'h000020fe, an, 16'h0, 1, 1);
      chk(rx[0], 8'ha5, "wide address read");
      cmd(OP_BLK_UNLOCK, 32'h01050000, an, 16'h0, 0, 0);
      lockchk(32'h01050000, 8'h00);
      lockchk(32'h00050000, 8'h01);
      @(negedge clk_sys);
      cfg.addr_4byte = 1'b0;
      an = 3;
   endtask

   task automatic t_reset();
      wait_idle();
      cmd(OP_GLB_UNLOCK, 0, 0, 16'h0, 0, 0);
      cmd(OP_RST_EN, 0, 0, 16'h0, 0, 0);
      lockchk(32'h50000, 8'h00);
      cmd(OP_RST, 0, 0, 16'h0, 0, 0);
      chk(sr_cnt[7:0], 8'h0, "reset after broken pair");
      @(negedge clk_sys);
      cfg.die_active = 1'b0;
      cmd(OP_RST_EN, 0, 0, 16'h0, 0, 0);
      cmd(OP_RST, 0, 0, 16'h0, 0, 0);
      chk(sr_cnt[7:0], 8'h1, "reset on idle die");
      chk({7'h0, stat.reset_recovery}, 8'h1, "recovery active");
      @(negedge clk_sys);
      cfg.die_active = 1'b1;
      cmd(OP_GLB_UNLOCK, 0, 0, 16'h0, 0, 0);
      wait_idle();
      lockchk(32'h50000, 8'h01);
   endtask

   initial begin
      rstn = 1'b0;
      cfg = '0;
      cfg.die_active = 1'b1;
      prog_check_block = '0;
      repeat (8) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (6) @(negedge clk_sys);
      t_locks();
      t_sec();
      t_addr4();
      t_reset();
      wrap_up();
   end
endmodule
